// ==== hdl/sadc_pkg.sv ====
/*
  package for the successive-approximation converter control block: register map, field positions,
  reset values, timing counts and carrier types.
  assumes a single 25 MHz clock shared with the cpu register port.
*/
// Notes on behaviour
// - finished result lands in 8-bit result register
// - input at high reference gives ff, no overflow
// - input at low reference gives zero
// - conversion 64 clocks, sampling 31.5 clocks (code samples 32, rounded up)
// - result scales linearly, 255 times input over span
// - bits 2:0 select one of eight inputs
// - after power-on settle, convert selected channel continuously
// - end of conversion sets done bit 7, no interrupt
// - control write aborts, clears done, restarts conversion
// - reading result clears the done flag
// - bit 5 powers converter on, clear stops it
// - bit 4 always reads zero
// - deep low-power disables converter, needs resettle
// - wait-for-interrupt leaves converter running
// - analog use keeps digital pin reads working
// - reset clears both registers to zero
package sadc_pkg;
  localparam logic [7:0] ADDR_RESULT          = 8'h70;
  localparam logic [7:0] ADDR_CONTROL_STATUS  = 8'h71;
  localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h72;
  localparam logic [7:0] ADDR_IRQ_MASK        = 8'h73;
  localparam int         BIT_DONE             = 7;
  localparam int         BIT_POWER            = 5;
  localparam int         BIT_RSVD4            = 4;
  localparam int         CHAN_MSB             = 2;
  localparam logic [7:0] CSR_RESET            = 8'h00;
  localparam logic [7:0] RESULT_RESET         = 8'h00;
  localparam logic [7:0] CSR_WRITE_MASK       = 8'h67;
  localparam logic [7:0] FULL_SCALE           = 8'hFF;
  localparam logic [7:0] ZERO_SCALE           = 8'h00;
  localparam int         CLK_HZ               = 25000000;
  localparam int         CONV_CYCLES          = 64;
  localparam int         SAMPLE_HALF_CYCLES   = 63;
  localparam int         SAMPLE_CYCLES        = (SAMPLE_HALF_CYCLES + 1) / 2;
  localparam int         SETTLE_US            = 30;
  localparam int         SETTLE_CYCLES        = (SETTLE_US * (CLK_HZ / 1000000) + 0);
  localparam int         NUM_BITS             = 8;
  localparam int         IRQ_BIT_DONE         = 0;
  localparam int         IRQ_BIT_OVERRUN      = 1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sadc_bus_type;
endpackage

// ==== hdl/sadc_settle.sv ====
/*
  settle timer: counts the stabilisation interval after power-on or wake.
  assumes power and halt inputs synchronous to clk_i.
*/
`timescale 1ns/100ps
module sadc_settle #(
  parameter int SETTLE_CYCLES = sadc_pkg::SETTLE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      ready_o
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  // any drop of run restarts the wait, so a halt wake resettles
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= '0;
      ready_o <= 1'b0;
    end else if (cnt_reg == CW'(SETTLE_CYCLES - 1)) begin
      ready_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// ==== hdl/sadc_sar.sv ====
/*
  successive-approximation engine: 32 sample cycles then 8 bit trials over 32 cycles.
  assumes comparator input valid one cycle after the trial code is shown.
*/
`timescale 1ns/100ps
module sadc_sar (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       abort_i,
  input  wire logic       cmp_above_i,
  output logic            sample_o,
  output logic [7:0]      trial_o,
  output logic            done_o,
  output logic [7:0]      value_o
);
  logic [5:0] cyc_reg;
  logic       busy_reg;
  logic [2:0] bit_idx;

  assign bit_idx = 3'(7 - ((cyc_reg - 6'(sadc_pkg::SAMPLE_CYCLES)) >> 2));

  // the half cycle of sampling is rounded up to a whole clock
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || abort_i) begin
      cyc_reg  <= '0;
      busy_reg <= 1'b0;
      sample_o <= 1'b0;
      trial_o  <= '0;
    end else if (!busy_reg) begin
      if (go_i) begin
        busy_reg <= 1'b1;
        sample_o <= 1'b1;
        cyc_reg  <= '0;
      end
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
      if (cyc_reg == 6'(sadc_pkg::SAMPLE_CYCLES - 1)) begin
        sample_o <= 1'b0;
        trial_o  <= 8'h80;
      end else if (cyc_reg >= 6'(sadc_pkg::SAMPLE_CYCLES) && cyc_reg[1:0] == 2'h3) begin
        // keep the bit if input is not below the trial level; linear binary weighting
        if (!cmp_above_i) trial_o[bit_idx] <= 1'b0;
        if (bit_idx != 3'h0) trial_o[bit_idx - 3'h1] <= 1'b1;
        if (cyc_reg == 6'(sadc_pkg::CONV_CYCLES - 1)) begin
          // restart on the same edge: an idle clock here would stretch the period to 65
          busy_reg <= go_i;
          sample_o <= go_i;
          done_o   <= 1'b1;
          value_o  <= {trial_o[7:1], trial_o[0] & cmp_above_i};
        end
      end
    end
  end
endmodule

// ==== hdl/sadc_top.sv ====
/*
  converter control block: register port, channel mux select, settle timer, sar engine,
  sticky event status with mask and one level interrupt.
  assumes cpu port synchronous to clk_i; comparator, mux and sample-and-hold are analog outside.
*/
`timescale 1ns/100ps
module sadc_top #(
  parameter int SETTLE_CYCLES = sadc_pkg::SETTLE_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       halt_i,
  input  wire logic       wait_i,
  input  wire logic       cmp_above_i,
  output logic [7:0]      rdata_o,
  output logic [2:0]      channel_select_o,
  output logic            sample_o,
  output logic [7:0]      trial_o,
  output logic            analog_power_o,
  output logic            irq_o
);
  sadc_pkg::sadc_bus_type bus;
  logic [7:0] control_status_reg;
  logic [7:0] result_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic       settled;
  logic       conv_done;
  logic [7:0] conv_value;
  logic       csr_wr;
  logic       result_rd;
  logic       status_rd;
  logic       running;
  logic       sample_int;
  logic [7:0] trial_int;

  assign bus       = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign csr_wr    = bus.wr && bus.addr == sadc_pkg::ADDR_CONTROL_STATUS;
  assign result_rd = bus.rd && bus.addr == sadc_pkg::ADDR_RESULT;
  assign status_rd = bus.rd && bus.addr == sadc_pkg::ADDR_IRQ_STATUS;
  // wait state is ignored on purpose: conversions carry on
  assign running   = control_status_reg[sadc_pkg::BIT_POWER] && !halt_i;

  sadc_settle #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (running),
    .ready_o (settled)
  );

  sadc_sar u_sar (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .go_i        (settled && running),
    .abort_i     (csr_wr || !running),
    .cmp_above_i (cmp_above_i),
    .sample_o    (sample_int),
    .trial_o     (trial_int),
    .done_o      (conv_done),
    .value_o     (conv_value)
  );

  // control/status: write keeps only writable bits, done flag is hardware owned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_status_reg <= sadc_pkg::CSR_RESET;
    end else begin
      if (csr_wr) begin
        control_status_reg[6:0] <= bus.wdata[6:0] & sadc_pkg::CSR_WRITE_MASK[6:0];
      end
      if (conv_done && !csr_wr) begin
        control_status_reg[sadc_pkg::BIT_DONE] <= 1'b1;
      end else if (csr_wr || result_rd) begin
        control_status_reg[sadc_pkg::BIT_DONE] <= 1'b0;
      end
    end
  end

  // result moves only with the done flag, so a read never sees a half-built code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= sadc_pkg::RESULT_RESET;
    end else if (conv_done && !csr_wr) begin
      result_reg <= conv_value;
    end
  end

  // side events: overrun = new result while previous one unread; converter itself raises none
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
    end else begin
      if (bus.wr && bus.addr == sadc_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= bus.wdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (status_rd) irq_status_reg[i] <= 1'b0;
      end
      if (conv_done && !csr_wr) begin
        irq_status_reg[sadc_pkg::IRQ_BIT_DONE] <= 1'b1;
        if (control_status_reg[sadc_pkg::BIT_DONE]) irq_status_reg[sadc_pkg::IRQ_BIT_OVERRUN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      // a finished conversion is only logged; it never pulls the line, overrun alone does
      irq_o <= irq_status_reg[sadc_pkg::IRQ_BIT_OVERRUN] & irq_mask_reg[sadc_pkg::IRQ_BIT_OVERRUN];
    end
  end

  // read port; unmapped addresses answer zero; digital pin reads live elsewhere, untouched here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (!bus.rd) begin
      rdata_o <= '0;
    end else if (bus.addr == sadc_pkg::ADDR_RESULT) begin
      rdata_o <= result_reg;
    end else if (bus.addr == sadc_pkg::ADDR_CONTROL_STATUS) begin
      rdata_o <= control_status_reg & ~(8'h01 << sadc_pkg::BIT_RSVD4);
    end else if (bus.addr == sadc_pkg::ADDR_IRQ_STATUS) begin
      rdata_o <= {6'h00, irq_status_reg};
    end else if (bus.addr == sadc_pkg::ADDR_IRQ_MASK) begin
      rdata_o <= {6'h00, irq_mask_reg};
    end else begin
      rdata_o <= '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_select_o <= '0;
      sample_o         <= 1'b0;
      trial_o          <= '0;
      analog_power_o   <= 1'b0;
    end else begin
      channel_select_o <= control_status_reg[sadc_pkg::CHAN_MSB:0];
      sample_o         <= sample_int;
      trial_o          <= trial_int;
      analog_power_o   <= running;
    end
  end
endmodule

// ==== tb/sadc_analog_model.sv ====
/*
  analog side model: eight input levels, channel mux and comparator against the trial code.
  assumes levels given as 8-bit codes, channel n in bits 8n+7:8n.
*/
`timescale 1ns/100ps
module sadc_analog_model (
  input  wire logic [2:0]  channel_select_i,
  input  wire logic [7:0]  trial_i,
  input  wire logic        power_i,
  input  wire logic [63:0] levels_i,
  output logic             cmp_above_o
);
  // unpowered comparator echoes trial code bit 0, never a usable answer
  assign cmp_above_o = power_i ? (levels_i[channel_select_i*8 +: 8] >= trial_i) : trial_i[0];
endmodule

// ==== tb/sadc_top_asserts.sv ====
/*
  checker for sadc_top port timing, bound to every instance.
  assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module sadc_top_asserts #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       halt_i,
  input wire logic       wait_i,
  input wire logic       cmp_above_i,
  input wire logic [7:0] rdata_o,
  input wire logic [2:0] channel_select_o,
  input wire logic       sample_o,
  input wire logic [7:0] trial_o,
  input wire logic       analog_power_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] seg_reg;
  logic       clean_reg;
  wire        csr_wr = wr_i && addr_i == 8'h71;
  // clean marks a conversion not cut short by a write or halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_reg   <= 8'h00;
      clean_reg <= 1'b0;
    end else begin
      if ($rose(sample_o)) seg_reg <= 8'h01;
      else if (seg_reg != 8'h00 && seg_reg != 8'hFF) seg_reg <= seg_reg + 8'h01;
      if (csr_wr || halt_i) clean_reg <= 1'b0;
      else if ($rose(sample_o)) clean_reg <= 1'b1;
    end
  end
  reset_outputs_a: assert property ($fell(rst_i) |-> rdata_o == 8'h00 && !analog_power_o && !irq_o && !sample_o)
    else $error("outputs not clear after reset");
  power_follow_a: assert property ((csr_wr && !halt_i) ##1 !halt_i |=> analog_power_o == $past(wdata_i[5], 2))
    else $error("power does not follow control bit");
  chan_follow_a: assert property (csr_wr |=> ##1 channel_select_o == $past(wdata_i[2:0], 2))
    else $error("channel select does not follow write");
  halt_off_a: assert property (halt_i [*3] |-> !analog_power_o && !sample_o)
    else $error("converter active in halt");
  off_idle_a: assert property (!analog_power_o [*3] |-> !sample_o)
    else $error("sampling while powered off");
  sample_len_a: assert property ($fell(sample_o) && clean_reg |-> seg_reg == 8'h20)
    else $error("sampling phase length wrong");
  conv_period_a: assert property ($rose(sample_o) && clean_reg |-> seg_reg == 8'h40)
    else $error("conversion period wrong");
  csr_rsvd_a: assert property ($past(rd_i) && $past(addr_i) == 8'h71 |-> rdata_o[4] == 1'b0 && rdata_o[3] == 1'b0)
    else $error("reserved control bit reads one");
  unmapped_zero_a: assert property (!$past(rd_i) || $past(addr_i) > 8'h73 || $past(addr_i) < 8'h70 |-> rdata_o == 8'h00)
    else $error("read data outside a register read");
endmodule
bind sadc_top sadc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .halt_i(halt_i), .wait_i(wait_i), .cmp_above_i(cmp_above_i),
  .rdata_o(rdata_o), .channel_select_o(channel_select_o), .sample_o(sample_o), .trial_o(trial_o),
  .analog_power_o(analog_power_o), .irq_o(irq_o));

// ==== tb/testbench.sv ====
/*
  testbench: random channel and level conversions, reset values, abort, halt, power off, irq.
  assumes sadc_top with a short settle count and the analog model on the far side.
*/
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, halt_i = 0, wait_i = 0;
  logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o, trial_o, rv;
  logic [2:0]  ch, channel_select_o;
  logic        sample_o, analog_power_o, irq_o, cmp_above_i;
  logic [63:0] lv = 0;
  int          bad_count = 0, checks = 0, seed = 32'hbdccd8f6;
  initial forever #20 clk_i = ~clk_i;
  sadc_top #(.SETTLE_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .halt_i(halt_i), .wait_i(wait_i), .cmp_above_i(cmp_above_i), .rdata_o(rdata_o),
    .channel_select_o(channel_select_o), .sample_o(sample_o), .trial_o(trial_o), .analog_power_o(analog_power_o),
    .irq_o(irq_o));
  sadc_analog_model am (.channel_select_i(channel_select_o), .trial_i(trial_o), .power_i(analog_power_o),
    .levels_i(lv), .cmp_above_o(cmp_above_i));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task wait_done;
    int n;
    n = 0; rv = 8'h00;
    while (!rv[7] && n < 200) begin rd(8'h71); n++; end
  endtask
  function logic [7:0] csr_exp(input logic d, input logic p, input logic [2:0] c);
    csr_exp = {d, 1'b0, p, 2'b00, c};
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h70); chk(rv, 8'h00);
    rd(8'h71); chk(rv, 8'h00);
    wr(8'h70, 8'h55); rd(8'h70); chk(rv, 8'h00);
    rd(8'h74); chk(rv, 8'h00);
    $display("reset test done");
    wr(8'h73, 8'h01);
    for (int i = 0; i < 10; i++) begin
      lv = {$random(seed), $random(seed)}; ch = 3'($random(seed));
      @(posedge clk_i);
      wait_i <= 1'($random(seed));
      if (i < 2) lv[ch*8 +: 8] = i ? 8'hFF : 8'h00;
      wr(8'h71, 8'h30 | ch);
      wait_done; chk(rv, csr_exp(1, 1, ch));
      chk({5'h00, channel_select_o}, {5'h00, ch});
      rd(8'h70); chk(rv, lv[ch*8 +: 8]);
      rd(8'h71); chk(rv, csr_exp(0, 1, ch));
      if (i == 3) begin
        wait_done; wr(8'h71, 8'h20 | ch);
        rd(8'h71); chk(rv, csr_exp(0, 1, ch));
      end
      $display("conversion test %0d done", i);
    end
    @(posedge clk_i);
    halt_i <= 1'b1; repeat (5) @(posedge clk_i);
    chk({7'h00, analog_power_o}, 8'h00);
    halt_i <= 1'b0;
    wait_done; rd(8'h70); chk(rv, lv[ch*8 +: 8]);
    chk({7'h00, irq_o}, 8'h00);
    // two results left unread make an overrun, the only event allowed on the line
    wr(8'h73, 8'h02); repeat (140) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    wr(8'h73, 8'h00); repeat (2) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    $display("halt and irq test done");
    wr(8'h71, {5'h00, ch}); rd(8'h72); repeat (100) @(posedge clk_i);
    rd(8'h71); chk(rv, csr_exp(0, 0, ch));
    chk({7'h00, sample_o}, 8'h00);
    wr(8'h73, 8'h03); repeat (2) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    $display("power off test done");
    finish_test;
  end
endmodule
